// ---- core/adc_dev_end.sv ----
// Converter end: serial port, control word and conversion timer
`timescale 1ns/100ps
`include "adc_link_map.svh"
module adc_dev_end
   import adc_link_pkg::*;
#(
   parameter int CONV_CYC = `CONV_CYCLES
)(
   input  wire logic                 SYS_CLK,
   input  wire logic                 RST,
   adc_link_if.device                LINK,
   input  wire logic [`RES_BITS-1:0] SAMPLE_IN,
   output logic      [`CH_BITS-1:0]  CHANNEL,
   output logic                      TWO_WIRE
);
   localparam int S_CLK = 0;
   localparam int S_FRM = 1;
   localparam int S_DIN = 2;
   localparam int S_CNV = 3;

   initial begin
      if (CONV_CYC < 1 || CONV_CYC > 255) $error("CONV_CYC out of range");
   end

   logic [3:0]           s1_reg, s2_reg, s3_reg, st_reg, st_next;
   logic [3:0]           cnt_reg, cnt_next;
   word_t                rx_reg, rx_next, tx_reg, tx_next, src;
   logic                 out_reg, out_next, dir_reg, dir_next, drv_reg, drv_next;
   logic [`CH_BITS-1:0]  ch_reg, ch_next;
   logic                 two_reg, two_next, busy_reg, busy_next;
   logic [7:0]           ccnt_reg, ccnt_next;
   logic [`RES_BITS-1:0] res_reg, res_next;
   logic                 din_oe_n_reg, din_oe_n_next, dout_oe_n_reg, dout_oe_n_next;
   logic                 rise, fall, soft_start;

   ////////////////////////////////////////////////////////////////
   // Three-stage samplers on every pin from the host
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         s1_reg <= 4'hf;
         s2_reg <= 4'hf;
         s3_reg <= 4'hf;
      end else begin
         s1_reg <= {LINK.convert_start_n, LINK.din_line, LINK.frame_n, LINK.sclk};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   ////////////////////////////////////////////////////////////////
   always_comb begin
      st_next = st_reg;
      for (int i = 0; i < 4; i++) begin
         if (s2_reg[i] == s3_reg[i]) st_next[i] = s3_reg[i];
      end
      rise       = st_next[S_CLK] & ~st_reg[S_CLK];
      fall       = ~st_next[S_CLK] & st_reg[S_CLK];
      soft_start = 1'b0;
      cnt_next   = cnt_reg;
      rx_next    = rx_reg;
      tx_next    = tx_reg;
      out_next   = out_reg;
      dir_next   = dir_reg;
      drv_next   = drv_reg;
      ch_next    = ch_reg;
      two_next   = two_reg;
      busy_next  = busy_reg;
      ccnt_next  = ccnt_reg;
      res_next   = res_reg;
      src        = (cnt_reg == 4'h0) ? {{(`WORD_BITS-`RES_BITS){1'b0}}, res_reg} : tx_reg;
      // Shifting runs whatever the converter is doing
      if (st_next[S_FRM]) begin
         cnt_next = 4'h0;
         dir_next = 1'b0;
         drv_next = 1'b0;
      end else begin
         if (fall) begin
            out_next = src[15];
            tx_next  = {src[14:0], 1'b0};
            if (dir_reg) drv_next = 1'b1;
         end
         if (rise) begin
            if (!dir_reg) rx_next = {rx_reg[14:0], st_next[S_DIN]};
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == 4'hf) begin
               if (!dir_reg && rx_next != 16'h0000) begin
                  ch_next    = rx_next[`CTL_CH_LSB +: `CH_BITS];
                  two_next   = rx_next[`CTL_TWO_WIRE_BIT];
                  soft_start = rx_next[`CTL_CONV_BIT];
               end
               if (two_next) begin
                  dir_next = ~dir_reg;
                  drv_next = 1'b0;
               end
            end
         end
      end
      // Conversion timer; starts while busy are dropped
      if (busy_reg) begin
         if (ccnt_reg == 8'h00) begin
            busy_next = 1'b0;
            res_next  = SAMPLE_IN;
         end else begin
            ccnt_next = ccnt_reg - 8'h01;
         end
      end else if (soft_start || (st_reg[S_CNV] & ~st_next[S_CNV])) begin
         busy_next = 1'b1;
         ccnt_next = 8'(CONV_CYC - 1);
      end
      din_oe_n_next  = ~drv_next;
      dout_oe_n_next = ~(~two_next & ~st_next[S_FRM]);
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         st_reg        <= 4'hf;
         cnt_reg       <= 4'h0;
         rx_reg        <= 16'h0000;
         tx_reg        <= 16'h0000;
         out_reg       <= 1'b0;
         dir_reg       <= 1'b0;
         drv_reg       <= 1'b0;
         ch_reg        <= 3'h0;
         two_reg       <= 1'b0;
         busy_reg      <= 1'b0;
         ccnt_reg      <= 8'h00;
         res_reg       <= 14'h0000;
         din_oe_n_reg  <= 1'b1;
         dout_oe_n_reg <= 1'b1;
      end else begin
         st_reg        <= st_next;
         cnt_reg       <= cnt_next;
         rx_reg        <= rx_next;
         tx_reg        <= tx_next;
         out_reg       <= out_next;
         dir_reg       <= dir_next;
         drv_reg       <= drv_next;
         ch_reg        <= ch_next;
         two_reg       <= two_next;
         busy_reg      <= busy_next;
         ccnt_reg      <= ccnt_next;
         res_reg       <= res_next;
         din_oe_n_reg  <= din_oe_n_next;
         dout_oe_n_reg <= dout_oe_n_next;
      end
   end

   assign LINK.busy          = busy_reg;
   assign LINK.dev_din_out   = out_reg;
   assign LINK.dev_din_oe_n  = din_oe_n_reg;
   assign LINK.dev_dout_out  = out_reg;
   assign LINK.dev_dout_oe_n = dout_oe_n_reg;
   assign CHANNEL            = ch_reg;
   assign TWO_WIRE           = two_reg;
endmodule

// ---- core/adc_host_end.sv ----
// Host end: register port, clock divider and transfer sequencer
`timescale 1ns/100ps
`include "adc_link_map.svh"
module adc_host_end
   import adc_link_pkg::*;
#(
   parameter int SCLK_HALF = `SCLK_HALF_DEF,
   parameter int PULSE_CYC = `CONVERT_START_N_PULSE_CYC,
   parameter int GUARD_CYC = `EOC_GUARD_CYC
)(
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   adc_link_if.host         LINK,
   input  wire logic [1:0]  ADDR,
   input  wire logic [15:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [15:0] RDATA
);
   // Below four cycles the pin samplers cannot see each half
   initial begin
      if (SCLK_HALF < `SCLK_HALF_MIN || SCLK_HALF < 4 || SCLK_HALF > 127) $error("SCLK_HALF out of range");
      if (PULSE_CYC < 1 || PULSE_CYC > 255) $error("PULSE_CYC out of range");
      if (GUARD_CYC < 8 || GUARD_CYC > 255) $error("GUARD_CYC out of range");
   end

   host_state_t state_reg, state_next;
   logic [2:0]  s1_reg, s2_reg, s3_reg, st_reg, st_next;
   logic [2:0]  cfg_reg, cfg_next;
   word_t       tx_reg, tx_next, rx_reg, rx_next, sh_reg, sh_next, rdata_reg, rdata_next;
   logic [7:0]  div_reg, div_next, tmr_reg, tmr_next;
   logic [4:0]  bits_reg, bits_next, caps_reg, caps_next;
   logic        sclk_reg, sclk_next, frame_n_reg, frame_n_next, cnv_n_reg, cnv_n_next;
   logic        dout_reg, dout_next, oe_n_reg, oe_n_next, rd_ph_reg, rd_ph_next;
   logic        two, line, go, finish;

   ////////////////////////////////////////////////////////////////
   // Three-stage samplers: busy, shared data, result data
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         // Busy idles low, data lines idle high: no false end-of-conversion after reset
         s1_reg <= 3'h6;
         s2_reg <= 3'h6;
         s3_reg <= 3'h6;
      end else begin
         s1_reg <= {LINK.dout_line, LINK.din_line, LINK.busy};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   ////////////////////////////////////////////////////////////////
   always_comb begin
      st_next = st_reg;
      for (int i = 0; i < 3; i++) begin
         if (s2_reg[i] == s3_reg[i]) st_next[i] = s3_reg[i];
      end
      two  = cfg_reg[`HC_TWO - 1];
      line = two ? st_reg[1] : st_reg[2];
      go   = WR && ADDR == `HREG_CTRL && WDATA[`HC_GO] && state_reg == H_IDLE;
      // Mode bits are frozen while a sequence runs
      cfg_next = (WR && ADDR == `HREG_CTRL && state_reg == H_IDLE) ? WDATA[3:1] : cfg_reg;
      tx_next  = (WR && ADDR == `HREG_TX) ? WDATA : tx_reg;
      rdata_next = 16'h0000;
      if (RD) begin
         unique case (ADDR)
            `HREG_CTRL: rdata_next = {12'h000, cfg_reg, 1'b0};
            `HREG_TX:   rdata_next = tx_reg;
            `HREG_RX:   rdata_next = rx_reg;
            `HREG_STAT: rdata_next = {13'h0000, st_reg[0], two, state_reg != H_IDLE};
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Sequencer: write, optional start pulse, wait, read
   always_comb begin
      state_next   = state_reg;
      rx_next      = rx_reg;
      sh_next      = sh_reg;
      div_next     = div_reg;
      tmr_next     = tmr_reg;
      bits_next    = bits_reg;
      caps_next    = caps_reg;
      sclk_next    = sclk_reg;
      frame_n_next = frame_n_reg;
      cnv_n_next   = cnv_n_reg;
      dout_next    = dout_reg;
      oe_n_next    = oe_n_reg;
      rd_ph_next   = rd_ph_reg;
      finish       = 1'b0;
      unique case (state_reg)
         H_IDLE: begin
            // Frame held low in two-wire; no clock goes out as master clock
            frame_n_next = ~two;
            sclk_next    = 1'b1;
            if (go) begin
               state_next   = H_LEAD;
               tmr_next     = 8'(SCLK_HALF - 1);
               frame_n_next = 1'b0;
               rd_ph_next   = 1'b0;
               bits_next    = 5'h00;
               caps_next    = 5'h00;
               oe_n_next    = 1'b0;
               // Only the control word goes out; other settings keep defaults
               // Mode from this write; cfg_reg only follows next cycle
               sh_next      = WDATA[`HC_TWO] ? (tx_reg | 16'(1 << `CTL_TWO_WIRE_BIT)) : tx_reg;
            end
         end
         H_LEAD, H_GAP: begin
            if (tmr_reg == 8'h00) begin
               state_next = H_SHIFT;
               div_next   = 8'h00;
            end else begin
               tmr_next = tmr_reg - 8'h01;
            end
         end
         H_SHIFT: begin
            if (div_reg != 8'h00) begin
               div_next = div_reg - 8'h01;
            end else begin
               div_next = 8'(SCLK_HALF - 1);
               if (!sclk_reg) begin
                  sclk_next = 1'b1;
                  bits_next = bits_reg + 5'h01;
               end else begin
                  // Late sampling leaves room for the far end's pin samplers
                  if (bits_reg != caps_reg) begin
                     caps_next = bits_reg;
                     if (!two || rd_ph_reg) rx_next = {rx_reg[14:0], line};
                  end
                  if (bits_reg == 5'h10) begin
                     finish = 1'b1;
                  end else if (two && bits_reg == 5'h08 && bits_reg != caps_reg) begin
                     state_next = H_GAP;
                     tmr_next   = 8'(2 * SCLK_HALF - 1);
                  end else begin
                     sclk_next = 1'b0;
                     dout_next = sh_reg[15];
                     sh_next   = {sh_reg[14:0], 1'b0};
                  end
               end
            end
         end
         H_START: begin
            if (tmr_reg == 8'h00) begin
               cnv_n_next = 1'b1;
               state_next = (cfg_reg[`HC_WAIT - 1] || two) ? H_WAIT : H_IDLE;
               tmr_next   = 8'(GUARD_CYC - 1);
            end else begin
               tmr_next = tmr_reg - 8'h01;
            end
         end
         H_WAIT: begin
            if (tmr_reg != 8'h00) begin
               tmr_next = tmr_reg - 8'h01;
            end else if (!st_reg[0]) begin
               if (two) begin
                  state_next = H_SHIFT;
                  rd_ph_next = 1'b1;
                  bits_next  = 5'h00;
                  caps_next  = 5'h00;
                  div_next   = 8'h00;
               end else begin
                  state_next = H_IDLE;
               end
            end
         end
      endcase
      if (finish) begin
         frame_n_next = ~two;
         oe_n_next    = 1'b1;
         tmr_next     = 8'(GUARD_CYC - 1);
         if (rd_ph_reg) begin
            state_next = H_IDLE;
         end else if (cfg_reg[`HC_HW - 1]) begin
            state_next = H_START;
            cnv_n_next = 1'b0;
            tmr_next   = 8'(PULSE_CYC - 1);
         end else begin
            state_next = (cfg_reg[`HC_WAIT - 1] || two) ? H_WAIT : H_IDLE;
         end
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         state_reg   <= H_IDLE;
         st_reg      <= 3'h6;
         cfg_reg     <= 3'h0;
         tx_reg      <= 16'h0000;
         rx_reg      <= 16'h0000;
         sh_reg      <= 16'h0000;
         rdata_reg   <= 16'h0000;
         div_reg     <= 8'h00;
         tmr_reg     <= 8'h00;
         bits_reg    <= 5'h00;
         caps_reg    <= 5'h00;
         sclk_reg    <= 1'b1;
         frame_n_reg <= 1'b1;
         cnv_n_reg   <= 1'b1;
         dout_reg    <= 1'b0;
         oe_n_reg    <= 1'b1;
         rd_ph_reg   <= 1'b0;
      end else begin
         state_reg   <= state_next;
         st_reg      <= st_next;
         cfg_reg     <= cfg_next;
         tx_reg      <= tx_next;
         rx_reg      <= rx_next;
         sh_reg      <= sh_next;
         rdata_reg   <= rdata_next;
         div_reg     <= div_next;
         tmr_reg     <= tmr_next;
         bits_reg    <= bits_next;
         caps_reg    <= caps_next;
         sclk_reg    <= sclk_next;
         frame_n_reg <= frame_n_next;
         cnv_n_reg   <= cnv_n_next;
         dout_reg    <= dout_next;
         oe_n_reg    <= oe_n_next;
         rd_ph_reg   <= rd_ph_next;
      end
   end

   assign LINK.sclk            = sclk_reg;
   assign LINK.frame_n         = frame_n_reg;
   assign LINK.convert_start_n = cnv_n_reg;
   assign LINK.host_din_out    = dout_reg;
   assign LINK.host_din_oe_n   = oe_n_reg;
   assign RDATA                = rdata_reg;
endmodule

// ---- core/adc_link_if.sv ----
// Serial link wires between host and converter
`timescale 1ns/100ps
interface adc_link_if;
   logic sclk;
   logic frame_n;
   logic convert_start_n;
   logic busy;
   logic host_din_out;
   logic host_din_oe_n;
   logic dev_din_out;
   logic dev_din_oe_n;
   logic dev_dout_out;
   logic dev_dout_oe_n;
   logic din_line;
   logic dout_line;
   // Pull-up when nobody drives; host wins a clash
   assign din_line  = !host_din_oe_n ? host_din_out : (!dev_din_oe_n ? dev_din_out : 1'b1);
   assign dout_line = !dev_dout_oe_n ? dev_dout_out : 1'b1;
   modport host (output sclk, frame_n, convert_start_n, host_din_out, host_din_oe_n,
                 input busy, din_line, dout_line);
   modport device (input sclk, frame_n, convert_start_n, din_line,
                   output busy, dev_din_out, dev_din_oe_n, dev_dout_out, dev_dout_oe_n);
endinterface

// ---- core/adc_link_map.svh ----
// Constants for the converter serial link, both ends
// What this block does
// - Host may write channel, wire-count and start bits
// - All-zero input word changes nothing
// - Shared clock needs frame low 16 clocks
// - Two-wire: clock plus shared data, frame low
// - Frame tied low: master clock supplied separately
// - Two-wire control write is two bytes
// - Conversion 3.5 us; wait before reading
// - Two-wire result read as two bytes
// - Start from host pin or control bit
// - Three-wire frame may stay tied low
// - Clock idles high, phase one
// - End-of-conversion usable as interrupt
// - Transfers accepted during conversion
// - Full duplex: write word, read previous result
// - Word host uses 16-bit frames
// - One active-low frame per 16-bit word
// - Inverted DSP clock: idle high at device
// - Gated serial clock never master clock
// - Serial clock up to 6 MHz
// - Two-wire direction flips each 16th rise
// - Two-wire writes keep wire-count bit set
// - First falling edge shifts first leading zero
`ifndef ADC_LINK_MAP_SVH
`define ADC_LINK_MAP_SVH
`define WORD_BITS        16
`define BYTE_BITS        8
`define RES_BITS         14
`define CH_BITS          3
`define CTL_CONV_BIT     0
`define CTL_TWO_WIRE_BIT 1
`define CTL_CH_LSB       2
`define SYS_CLK_KHZ      25000
`define CONV_TIME_NS     3500
`define CONV_CYCLES      ((`CONV_TIME_NS * `SYS_CLK_KHZ + 999999) / 1000000)
`define SCLK_MAX_KHZ     6000
`define SCLK_HALF_MIN    ((`SYS_CLK_KHZ + 2 * `SCLK_MAX_KHZ - 1) / (2 * `SCLK_MAX_KHZ))
`define SCLK_HALF_DEF    6
`define CONVERT_START_N_PULSE_NS  100
`define CONVERT_START_N_PULSE_CYC ((`CONVERT_START_N_PULSE_NS * `SYS_CLK_KHZ + 999999) / 1000000)
`define EOC_GUARD_CYC    12
`define HREG_CTRL        2'h0
`define HREG_TX          2'h1
`define HREG_RX          2'h2
`define HREG_STAT        2'h3
`define HC_GO            0
`define HC_TWO           1
`define HC_HW            2
`define HC_WAIT          3
`endif

// ---- core/adc_link_pkg.sv ----
// Types shared by both ends of the converter link
package adc_link_pkg;
   typedef enum logic [2:0] {H_IDLE, H_LEAD, H_SHIFT, H_GAP, H_START, H_WAIT} host_state_t;
   typedef logic [15:0] word_t;
endpackage

// ---- verif/adc_link_checker_sva.sv ----
// Assertions on the serial link wires between host and converter
`timescale 1ns/100ps
module adc_link_checker #(
   parameter int CONV_CYC = 88
)(
   input logic SYS_CLK,
   input logic RST,
   input logic sclk,
   input logic frame_n,
   input logic convert_start_n,
   input logic busy,
   input logic host_din_oe_n,
   input logic dev_din_oe_n,
   input logic dev_dout_oe_n,
   input logic dout_line
);
   logic       sclk_q;
   logic       sclk_rise;
   logic [4:0] rise_cnt;
   logic [9:0] busy_cnt;
   assign sclk_rise = sclk & ~sclk_q;
   ////////////////////////////////////////////////////////////////
   // Rise count wraps at 16 so a frame held low keeps word phase
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         sclk_q   <= 1'b1;
         rise_cnt <= 5'h00;
         busy_cnt <= 10'h000;
      end else begin
         sclk_q   <= sclk;
         busy_cnt <= busy ? busy_cnt + 10'h001 : 10'h000;
         if (frame_n) begin
            rise_cnt <= 5'h00;
         end else if (sclk_rise) begin
            rise_cnt <= (rise_cnt == 5'h10) ? 5'h01 : rise_cnt + 5'h01;
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   property p_idle_high; frame_n |-> sclk; endproperty
   a_idle_high: assert property (p_idle_high) else $error("sclk low outside frame");
   property p_frame_len; $rose(frame_n) |-> rise_cnt == 5'h10; endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame not 16 clocks");
   property p_lead_zero;
      sclk_rise && rise_cnt < 5'h02 && !frame_n && !dev_dout_oe_n |-> !dout_line;
   endproperty
   a_lead_zero: assert property (p_lead_zero) else $error("leading zeros missing");
   property p_conv_len; $fell(busy) |-> busy_cnt == 10'(CONV_CYC); endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
   property p_start_pulse;
      $fell(convert_start_n) |-> !convert_start_n[*3] ##1 convert_start_n;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start pulse width wrong");
   property p_start_busy; $fell(convert_start_n) |-> ##[1:8] busy; endproperty
   a_start_busy: assert property (p_start_busy) else $error("busy did not follow start");
   property p_no_clash; !(!host_din_oe_n && !dev_din_oe_n); endproperty
   a_no_clash: assert property (p_no_clash) else $error("both ends drive data line");
   property p_dir_flip; $changed(dev_din_oe_n) && !frame_n |-> rise_cnt == 5'h10; endproperty
   a_dir_flip: assert property (p_dir_flip) else $error("direction flip off word edge");
   property p_release; $rose(frame_n) |-> ##[1:6] dev_dout_oe_n; endproperty
   a_release: assert property (p_release) else $error("result line not released");
   c_frame: cover property ($rose(frame_n));
   c_two_wire: cover property ($fell(dev_din_oe_n));
   c_pulse: cover property ($fell(convert_start_n));
endmodule

// ---- verif/test_adc_serial_host_interface.sv ----
// Self-checking bench joining host end and converter end
`timescale 1ns/100ps
`include "adc_link_map.svh"
module test_adc_serial_host_interface;
   import adc_link_pkg::*;
   // Longest the 8-bit timer holds; the overlap scenario needs the margin
   localparam int CONV = 255;
   logic        SYS_CLK;
   logic        RST;
   logic [1:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic [13:0] sample_in;
   logic [2:0]  channel;
   logic        two_wire;
   int          n_errors;
   int          checks;
   logic [15:0] rv;
   logic [13:0] smp;
   logic [13:0] smp_new;
   logic [2:0]  ch;
   logic [2:0]  ch_exp;
   logic        hw;
   adc_link_if adc_link_if_inst();
   adc_host_end #(.SCLK_HALF(6), .PULSE_CYC(3), .GUARD_CYC(12)) adc_host_end_inst (
      .SYS_CLK(SYS_CLK), .RST(RST), .LINK(adc_link_if_inst.host), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata));
   adc_dev_end #(.CONV_CYC(CONV)) adc_dev_end_inst (.SYS_CLK(SYS_CLK), .RST(RST),
      .LINK(adc_link_if_inst.device), .SAMPLE_IN(sample_in), .CHANNEL(channel), .TWO_WIRE(two_wire));
   adc_link_checker #(.CONV_CYC(CONV)) adc_link_checker_inst (.SYS_CLK(SYS_CLK), .RST(RST),
      .sclk(adc_link_if_inst.sclk), .frame_n(adc_link_if_inst.frame_n),
      .convert_start_n(adc_link_if_inst.convert_start_n), .busy(adc_link_if_inst.busy),
      .host_din_oe_n(adc_link_if_inst.host_din_oe_n), .dev_din_oe_n(adc_link_if_inst.dev_din_oe_n),
      .dev_dout_oe_n(adc_link_if_inst.dev_dout_oe_n), .dout_line(adc_link_if_inst.dout_line));
   ////////////////////////////////////////////////////////////////
   function automatic word_t ctl_word(input logic [2:0] c, input logic conv);
      return {11'h000, c, 1'b0, conv};
   endfunction
   function automatic word_t result_word(input logic [13:0] s);
      return {2'b00, s};
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
      checks++;
      if (seen !== expv) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask
   task automatic print_verdict();
      $display("Checks %0d, errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge SYS_CLK);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge SYS_CLK);
      wr    <= 1'b0;
   endtask
   task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge SYS_CLK);
      addr <= a;
      rd   <= 1'b1;
      @(posedge SYS_CLK);
      rd   <= 1'b0;
      @(negedge SYS_CLK);
      d = rdata;
   endtask
   // Polling keeps every wait bounded; a stuck sequencer ends the run
   task automatic wait_stat(input int bitn, input logic val);
      logic [15:0] s;
      for (int i = 0; i < 3000; i++) begin
         reg_rd(`HREG_STAT, s);
         if (s[bitn] === val) return;
      end
      $display("CHECK FAILED at %0t: status wait timed out, bit %h", $time, bitn);
      n_errors++;
      print_verdict();
   endtask
   task automatic transfer(input word_t w, input logic [15:0] ctl);
      reg_wr(`HREG_TX, w);
      reg_wr(`HREG_CTRL, ctl);
      wait_stat(0, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      SYS_CLK = 1'b0;
      forever #20 SYS_CLK = ~SYS_CLK;
   end
   initial begin
      RST = 1'b1;
      addr = 2'h0;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      sample_in = 14'h0000;
      n_errors = 0;
      checks = 0;
      smp = 14'h0000;
      ch_exp = 3'h0;
      void'($urandom(32'h4c5a63a5));
      repeat (20) @(posedge SYS_CLK);
      RST <= 1'b0;
      repeat (4) @(posedge SYS_CLK);
      @(negedge SYS_CLK);
      chk(rdata, 16'h0000);
      chk({13'h0000, channel}, 16'h0000);
      chk({15'h0000, two_wire}, 16'h0000);
      reg_rd(`HREG_STAT, rv);
      chk(rv, 16'h0000);
      // Three-wire: each word starts a conversion and returns the previous result
      for (int i = 0; i < 6; i++) begin
         ch = 3'($urandom);
         smp_new = (i == 0) ? 14'h3fff : 14'($urandom);
         hw = (i % 3 == 2);
         sample_in <= smp_new;
         // An all-zero word keeps the old channel
         if (ctl_word(ch, !hw) != 16'h0000) ch_exp = ch;
         transfer(ctl_word(ch, !hw), {12'h000, i[0], hw, 2'b01});
         reg_rd(`HREG_RX, rv);
         if (i > 0) chk(rv, result_word(smp));
         chk({13'h0000, channel}, {13'h0000, ch_exp});
         if (i[0]) begin
            reg_rd(`HREG_STAT, rv);
            chk({15'h0000, rv[2]}, 16'h0000);
         end else begin
            wait_stat(2, 1'b1);
         end
         wait_stat(2, 1'b0);
         smp = smp_new;
      end
      // All-zero word: no channel change and no conversion
      transfer(16'h0000, 16'h0001);
      reg_rd(`HREG_RX, rv);
      chk(rv, result_word(smp));
      chk({13'h0000, channel}, {13'h0000, ch_exp});
      repeat (10) @(posedge SYS_CLK);
      reg_rd(`HREG_STAT, rv);
      chk({15'h0000, rv[2]}, 16'h0000);
      // Second word lands while the first conversion still runs
      sample_in <= 14'h2a5c;
      transfer(ctl_word(3'h5, 1'b1), 16'h0001);
      transfer(ctl_word(3'h2, 1'b0), 16'h0001);
      reg_rd(`HREG_STAT, rv);
      chk({15'h0000, rv[2]}, 16'h0001);
      chk({13'h0000, channel}, 16'h0002);
      reg_rd(`HREG_RX, rv);
      chk(rv, result_word(smp));
      wait_stat(2, 1'b0);
      smp = 14'h2a5c;
      // Two-wire: write, wait for end of conversion, read back on shared line
      for (int j = 0; j < 2; j++) begin
         ch = 3'($urandom);
         smp_new = 14'($urandom);
         sample_in <= smp_new;
         transfer(ctl_word(ch, j == 0), {13'h0000, j == 1, 2'b11});
         reg_rd(`HREG_RX, rv);
         chk(rv, result_word(smp_new));
         chk({13'h0000, channel}, {13'h0000, ch});
         chk({15'h0000, two_wire}, 16'h0001);
         reg_rd(`HREG_STAT, rv);
         chk(rv, 16'h0002);
         reg_rd(`HREG_CTRL, rv);
         chk(rv, {12'h000, 1'b0, j == 1, 2'b10});
         reg_rd(`HREG_TX, rv);
         chk(rv, ctl_word(ch, j == 0));
      end
      print_verdict();
   end
endmodule
